// file: dv/pdc_host_model.sv
// apb host model that programs the configuration words
`timescale 1ns/1ns
module pdc_host_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	// apb answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// ================================================================
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
	end
	// one transfer; request held until ready is sampled high
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		// the host never sets the reserved lower-word bits
		if (w && a == 32'h0000_0000)
			d[23:22] = 2'b00;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		// a slave that never answers ends the run
		if (pready !== 1'b1) begin
			pdc_top_tb_top.errors++;
			pdc_top_tb_top.tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle cycle so psel is never assigned twice in one step
		@(posedge pclk);
	endtask : xfer
endmodule : pdc_host_model

// file: dv/pdc_top_sva.sv
// assertion checker on the pll divider configuration top ports
`timescale 1ns/1ns
module pdc_top_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// decoded selects
	input wire logic osc_speed_range_sel,
	input wire logic filter_time_const_sel,
	input wire pdc_pkg::pdc_pump_t main_pump_strength,
	input wire pdc_pkg::pdc_pump_t xtal_pump_strength,
	input wire logic [11:0] xtal_div_value,
	input wire logic xtal_osc_powerdown,
	input wire logic xtal_fine_tune_en,
	input wire logic xtal_polarity_invert,
	input wire logic xtal_loop_powerdown,
	input wire logic [3:0] xtal_coarse_code
);
	// ================================================================
	// one clock domain, so one default clock and reset
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup phase of any transfer
	sequence setup_ph;
		psel && !penable;
	endsequence
	// write stored into the upper word; outputs follow two edges on
	sequence wr_hi;
		psel && penable && pready && pwrite && paddr == 32'h0000_0004;
	endsequence
	// ================================================================
	// bus timing and decode
	chk_ready_next: assert property (setup_ph |=> pready)
		else $error("ready missing after setup");
	chk_speed_bit: assert property (wr_hi |-> ##2
		osc_speed_range_sel == $past(pwdata[12], 2)) else $error("speed");
	chk_filter_bit: assert property (wr_hi |-> ##2
		filter_time_const_sel == $past(pwdata[11], 2)) else $error("tc");
	chk_main_pump: assert property (wr_hi |-> ##2
		main_pump_strength == $past(pwdata[9:8], 2)) else $error("pump");
	chk_xtal_pump: assert property (wr_hi |-> ##2
		xtal_pump_strength == $past(pwdata[21:20], 2)) else $error("xpump");
	chk_xtal_flags: assert property (wr_hi |-> ##2
		{xtal_loop_powerdown, xtal_polarity_invert} ==
		$past(pwdata[23:22], 2)) else $error("xtal flags");
	chk_fine_coarse: assert property (wr_hi |-> ##2
		{xtal_fine_tune_en, xtal_coarse_code} ==
		{$past(pwdata[29], 2), $past(pwdata[27:24], 2)})
		else $error("fine or coarse");
	chk_xtal_sel: assert property (wr_hi |-> ##2
		xtal_osc_powerdown == ($past(pwdata[19:17], 2) == 3'h7))
		else $error("osc powerdown");
	chk_xtal_off: assert property (
		xtal_osc_powerdown == (xtal_div_value == 12'h000))
		else $error("table value versus powerdown");
endmodule : pdc_top_chk

bind pdc_top pdc_top_chk pdc_top_chk_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready),
	.osc_speed_range_sel(osc_speed_range_sel),
	.filter_time_const_sel(filter_time_const_sel),
	.main_pump_strength(main_pump_strength),
	.xtal_pump_strength(xtal_pump_strength),
	.xtal_div_value(xtal_div_value), .xtal_osc_powerdown(xtal_osc_powerdown),
	.xtal_fine_tune_en(xtal_fine_tune_en),
	.xtal_polarity_invert(xtal_polarity_invert),
	.xtal_loop_powerdown(xtal_loop_powerdown),
	.xtal_coarse_code(xtal_coarse_code));

// file: dv/pdc_top_tb_top.sv
// self-checking bench for the pll divider configuration block
`timescale 1ns/1ns
module pdc_top_tb_top;
	// ================================================================
	// clock, reset, bus and output wires
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rd_data;
	logic osc_speed_range_sel, filter_time_const_sel, xtal_osc_powerdown;
	logic xtal_fine_tune_en, xtal_polarity_invert, xtal_loop_powerdown;
	pdc_pkg::pdc_pump_t main_pump_strength, xtal_pump_strength;
	logic [11:0] xtal_div_value;
	logic [3:0] xtal_coarse_code;
	logic [2:0] div_outs; // post, feedback, reference
	logic rd_err;
	logic [63:0] mcfg; // model of the configuration word
	logic [31:0] seed = 32'h0000_9c65;
	int errors = 0;
	int total_checks = 0;
	int p;
	int xtab[8] = '{1, 3072, 3156, 2430, 2500, 4000, 3375, 0};
	int pa[4] = '{1, 2, 4, 8};
	int pb[4] = '{1, 3, 5, 4};
	int ca[4] = '{1, 2, 3, 0};
	int cb[4] = '{1, 2, 3, 1};
	int cc[4] = '{0, 1, 3, 2};
	always #20 pclk = ~pclk;
	// ================================================================
	// design and host
	pdc_top pdc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.osc_speed_range_sel(osc_speed_range_sel),
		.filter_time_const_sel(filter_time_const_sel),
		.main_pump_strength(main_pump_strength),
		.xtal_pump_strength(xtal_pump_strength),
		.xtal_div_value(xtal_div_value),
		.xtal_osc_powerdown(xtal_osc_powerdown),
		.xtal_fine_tune_en(xtal_fine_tune_en),
		.xtal_polarity_invert(xtal_polarity_invert),
		.xtal_loop_powerdown(xtal_loop_powerdown),
		.xtal_coarse_code(xtal_coarse_code), .ref_div_out(div_outs[0]),
		.fb_div_out(div_outs[1]), .post_div_out(div_outs[2]));
	pdc_host_model pdc_host_model_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	// ================================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	task automatic bus(input logic w, input logic [31:0] a, d);
		pdc_host_model_inst.xfer(w, a, d, rd_data, rd_err);
	endtask : bus
	// cycles between two rising edges of one divider output
	task automatic period(input int k, output int q);
		int n, m;
		logic last;
		m = -1;
		last = div_outs[k];
		for (n = 0; n < 800; n++) begin
			@(posedge pclk);
			if (div_outs[k] === 1'b1 && last !== 1'b1) begin
				if (m >= 0)
					break;
				m = n;
			end
			last = div_outs[k];
		end
		q = n - m;
		// a divider that stops toggling ends the run
		if (n == 800) begin
			errors++;
			tally_and_finish();
		end
	endtask : period
	// ================================================================
	// main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		bus(0, 0, 0);
		check(rd_data, 32'h0000_0001);
		bus(0, 4, 0);
		check(rd_data, 0);
		check(xtal_div_value, 1);
		// every crystal table code under random upper-word contents
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			mcfg[63:32] = seed;
			// long feedback moduli would outlast the later period waits
			mcfg[37:32] = 6'h00;
			mcfg[51:49] = i[2:0];
			bus(1, 4, mcfg[63:32]);
			repeat (2) @(posedge pclk);
			check(osc_speed_range_sel, mcfg[44]);
			check(filter_time_const_sel, mcfg[43]);
			check(main_pump_strength, mcfg[41:40]);
			check(xtal_pump_strength, mcfg[53:52]);
			check(xtal_div_value, xtab[i]);
			check(xtal_osc_powerdown, i == 7);
			check(xtal_fine_tune_en, mcfg[61]);
			check(xtal_polarity_invert, mcfg[54]);
			check(xtal_loop_powerdown, mcfg[55]);
			check(xtal_coarse_code, mcfg[59:56]);
		end
		// divider moduli; second period is after the reload
		for (int j = 0; j < 4; j++) begin
			mcfg[31:0] = {5'(j), 3'h3, 2'b11, 2'(cc[j]), 2'(cb[j]),
				2'(ca[j]), 4'h0, 12'(2 + 3 * j)};
			mcfg[37:32] = 6'h00;
			bus(1, 0, mcfg[31:0]);
			bus(1, 4, mcfg[63:32]);
			bus(0, 0, 0);
			check(rd_data, mcfg[31:0] & 32'hff3f_ffff);
			period(0, p);
			period(0, p);
			check(p, 2 + 3 * j);
			period(1, p);
			period(1, p);
			check(p, j * 8 + 3);
			period(2, p);
			period(2, p);
			check(p, pa[ca[j]] * pb[cb[j]] * pb[cc[j]]);
		end
		// refused accesses leave the upper word untouched
		bus(0, 32'h0000_000c, 0);
		check({rd_err, rd_data}, {1'b1, 32'h0000_0000});
		bus(1, 32'h0000_0008, 0);
		check(rd_err, 1);
		bus(1, 32'h0000_0104, 0);
		check(rd_err, 1);
		bus(0, 4, 0);
		check(rd_data, mcfg[63:32]);
		tally_and_finish();
	end
endmodule : pdc_top_tb_top

// file: src/pdc_divider.sv
// programmable modulus divider that reloads only at terminal count
`timescale 1ns/1ns
`include "pdc_map.svh"

module pdc_divider (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// input tick and requested modulus
	input wire logic tick_in,
	input wire pdc_pkg::pdc_mod_t modulus,
	// divided tick and square output
	output logic tick_out,
	output logic clk_out
);
	// ================================================================
	// state
	pdc_pkg::pdc_mod_t cnt_reg; // counts up to one below the active modulus
	pdc_pkg::pdc_mod_t mod_reg; // modulus in force this period
	logic tick_reg;
	logic clk_reg;

	// a modulus of zero behaves as divide by one
	wire pdc_pkg::pdc_mod_t mod_safe = (modulus == '0) ?
		pdc_pkg::pdc_mod_t'(1) : modulus;
	wire last = (cnt_reg >= mod_reg - pdc_pkg::pdc_mod_t'(1));
	wire pdc_pkg::pdc_mod_t cnt_next = last ? '0 :
		cnt_reg + pdc_pkg::pdc_mod_t'(1);
	wire pdc_pkg::pdc_mod_t half = mod_reg >> 1;

	// ================================================================
	// counter: new modulus taken only when a period ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= '0;
			mod_reg <= pdc_pkg::pdc_mod_t'(1);
			tick_reg <= 1'b0;
			clk_reg <= 1'b0;
		end else begin
			tick_reg <= tick_in & last;
			if (tick_in) begin
				cnt_reg <= cnt_next;
				// no truncated period: reload only at wrap
				if (last) mod_reg <= mod_safe;
				// low for the first half, high for the rest
				clk_reg <= last ? (mod_reg == pdc_pkg::pdc_mod_t'(1)) ?
					~clk_reg : 1'b0 : (cnt_next >= half);
			end else if (mod_reg == pdc_pkg::pdc_mod_t'(1)) begin
				// divide by one on a sparse tick: one high cycle per tick,
				// so the output period equals the tick period, not twice it
				clk_reg <= 1'b0;
			end
		end
	end

	assign tick_out = tick_reg;
	assign clk_out = clk_reg;
endmodule : pdc_divider

// file: src/pdc_map.svh
// register offsets, field positions, reset values and timing figures
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

// ====================================================================
// register byte offsets on the apb bus
`define PDC_OFS_CFG_LO 8'h00
`define PDC_OFS_CFG_HI 8'h04
`define PDC_OFS_STATUS 8'h08
`define PDC_ADDR_W 8

// ====================================================================
// reset values of the configuration words
`define PDC_CFG_LO_RST 32'h0000_0001
`define PDC_CFG_HI_RST 32'h0000_0000

// ====================================================================
// field positions inside the 64-bit configuration word
`define PDC_REF_DIV_HI 11
`define PDC_REF_DIV_LO 0
`define PDC_POST_A_HI 17
`define PDC_POST_A_LO 16
`define PDC_POST_B_HI 19
`define PDC_POST_B_LO 18
`define PDC_POST_C_HI 21
`define PDC_POST_C_LO 20
`define PDC_RSVD_HI 23
`define PDC_RSVD_LO 22
`define PDC_FB_A_HI 26
`define PDC_FB_A_LO 24
`define PDC_FB_M_HI 37
`define PDC_FB_M_LO 27
`define PDC_MAIN_PUMP_HI 41
`define PDC_MAIN_PUMP_LO 40
`define PDC_FILTER_TC_BIT 43
`define PDC_SPEED_BIT 44
`define PDC_XTAL_SEL_HI 51
`define PDC_XTAL_SEL_LO 49
`define PDC_XTAL_PUMP_HI 53
`define PDC_XTAL_PUMP_LO 52
`define PDC_XTAL_SWAP_BIT 54
`define PDC_XTAL_PD_BIT 55
`define PDC_XTAL_COARSE_HI 59
`define PDC_XTAL_COARSE_LO 56
`define PDC_XTAL_FINE_BIT 61

// ====================================================================
// divider constants
`define PDC_DIV_W 14
`define PDC_PRESCALE_SHIFT 3
`define PDC_XTAL_SEL_OFF 3'h7

// ====================================================================
// loop filter time constants, in ns, and their length in pclk cycles
`define PDC_CLK_PERIOD_NS 40
`define PDC_TC_SHORT_NS 13500
`define PDC_TC_LONG_NS 135000
`define PDC_TC_SHORT_CYC (`PDC_TC_SHORT_NS / `PDC_CLK_PERIOD_NS)
`define PDC_TC_LONG_CYC (`PDC_TC_LONG_NS / `PDC_CLK_PERIOD_NS)

`endif

// file: src/pdc_pkg.sv
// types shared by the pll divider configuration block
package pdc_pkg;
	// ================================================================
	// pump strength codes, 1.5 / 5 / 8 / 24 microamps
	typedef enum logic [1:0] {
		PDC_PUMP_1U5,
		PDC_PUMP_5U,
		PDC_PUMP_8U,
		PDC_PUMP_24U
	} pdc_pump_t;

	// divider modulus word
	typedef logic [13:0] pdc_mod_t;
endpackage : pdc_pkg

// file: src/pdc_top.sv
// pll divider configuration: apb register file, decode, divider chain
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "pdc_map.svh"

// How it works
// - bit 44 selects oscillator speed range
// - bit 43 selects short or long filter
// - reference modulus from bits 11 to 0
// - stage a divides by 1,2,4,8
// - stage b divides by 1,3,5,4
// - stage c divides by 1,3,5,4
// - bits 53-52 give crystal pump strength
// - bits 51-49 pick fixed crystal divider
// - all-ones select powers crystal oscillator down
// - bit 61 enables crystal fine tuning
// - bit 54 inverts crystal correction polarity
// - bit 55 powers crystal loop down
// - bits 59-56 drive coarse tune code
module pdc_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// main loop selects
	output logic osc_speed_range_sel,
	output logic filter_time_const_sel,
	output pdc_pkg::pdc_pump_t main_pump_strength,
	// crystal loop selects
	output pdc_pkg::pdc_pump_t xtal_pump_strength,
	output logic [11:0] xtal_div_value,
	output logic xtal_osc_powerdown,
	output logic xtal_fine_tune_en,
	output logic xtal_polarity_invert,
	output logic xtal_loop_powerdown,
	output logic [3:0] xtal_coarse_code,
	// divider outputs
	output logic ref_div_out,
	output logic fb_div_out,
	output logic post_div_out
);
	// ================================================================
	// post divider code decode, shared by the three stages
	function automatic pdc_pkg::pdc_mod_t post_mod(input logic [1:0] c,
		input logic pow2);
		case (c)
			2'h0: post_mod = 14'd1;
			2'h1: post_mod = pow2 ? 14'd2 : 14'd3;
			2'h2: post_mod = pow2 ? 14'd4 : 14'd5;
			default: post_mod = pow2 ? 14'd8 : 14'd4;
		endcase
	endfunction : post_mod

	// ================================================================
	// configuration word storage
	logic [31:0] cfg_lo_reg; // bits 31..0
	logic [31:0] cfg_hi_reg; // bits 63..32
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	wire logic [63:0] cfg = {cfg_hi_reg, cfg_lo_reg};

	// ================================================================
	// bus decode
	wire logic [7:0] addr = paddr[7:0];
	wire logic setup = psel & ~penable;
	wire logic hit_lo = (paddr[31:8] == 24'h00_0000) &
		(addr == `PDC_OFS_CFG_LO);
	wire logic hit_hi = (paddr[31:8] == 24'h00_0000) &
		(addr == `PDC_OFS_CFG_HI);
	wire logic hit_st = (paddr[31:8] == 24'h00_0000) &
		(addr == `PDC_OFS_STATUS);
	wire logic mapped = hit_lo | hit_hi | hit_st;
	// status is read only: a write to it is refused
	wire logic bad = ~mapped | (pwrite & hit_st);
	wire logic wr_fire = psel & penable & pready_reg & pwrite & ~pslverr_reg;
	wire logic [31:0] status_word = {29'h0000_0000, post_div_out,
		fb_div_out, ref_div_out};
	wire logic [31:0] rd_mux = hit_lo ? cfg_lo_reg :
		hit_hi ? cfg_hi_reg : hit_st ? status_word : 32'h0000_0000;
	// reserved bits forced to zero whatever the host sends
	wire logic [31:0] lo_mask = ~(32'h0000_0003 << `PDC_RSVD_LO);

	// ================================================================
	// apb answer: one wait-free access phase after every setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup & bad;
			if (setup) prdata_reg <= (pwrite | bad) ? 32'h0000_0000 : rd_mux;
		end
	end

	// ================================================================
	// configuration writes take effect at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_lo_reg <= `PDC_CFG_LO_RST;
			cfg_hi_reg <= `PDC_CFG_HI_RST;
		end else if (wr_fire) begin
			if (hit_lo) cfg_lo_reg <= pwdata & lo_mask;
			if (hit_hi) cfg_hi_reg <= pwdata;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// ================================================================
	// analog select outputs, registered from the configuration word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_speed_range_sel <= 1'b0;
			filter_time_const_sel <= 1'b0;
			main_pump_strength <= pdc_pkg::PDC_PUMP_1U5;
			xtal_pump_strength <= pdc_pkg::PDC_PUMP_1U5;
			xtal_fine_tune_en <= 1'b0;
			xtal_polarity_invert <= 1'b0;
			xtal_loop_powerdown <= 1'b0;
			xtal_coarse_code <= 4'h0;
		end else begin
			// 0 high speed range, 1 low speed range
			osc_speed_range_sel <= cfg[`PDC_SPEED_BIT];
			// 0 short constant, 1 long constant
			filter_time_const_sel <= cfg[`PDC_FILTER_TC_BIT];
			main_pump_strength <= pdc_pkg::pdc_pump_t'(
				cfg[`PDC_MAIN_PUMP_HI:`PDC_MAIN_PUMP_LO]);
			xtal_pump_strength <= pdc_pkg::pdc_pump_t'(
				cfg[`PDC_XTAL_PUMP_HI:`PDC_XTAL_PUMP_LO]);
			xtal_fine_tune_en <= cfg[`PDC_XTAL_FINE_BIT];
			xtal_polarity_invert <= cfg[`PDC_XTAL_SWAP_BIT];
			xtal_loop_powerdown <= cfg[`PDC_XTAL_PD_BIT];
			xtal_coarse_code <=
				cfg[`PDC_XTAL_COARSE_HI:`PDC_XTAL_COARSE_LO];
		end
	end

	// ================================================================
	// crystal divider table
	pdc_xtal_decode u_xtal (
		.pclk(pclk),
		.presetn(presetn),
		.sel(cfg[`PDC_XTAL_SEL_HI:`PDC_XTAL_SEL_LO]),
		.div_value(xtal_div_value),
		.osc_powerdown(xtal_osc_powerdown)
	);

	// ================================================================
	// divider moduli
	wire pdc_pkg::pdc_mod_t ref_mod = pdc_pkg::pdc_mod_t'(
		cfg[`PDC_REF_DIV_HI:`PDC_REF_DIV_LO]);
	// prescaler of eight: modulus = M*8 + A
	wire pdc_pkg::pdc_mod_t fb_mod =
		(pdc_pkg::pdc_mod_t'(cfg[`PDC_FB_M_HI:`PDC_FB_M_LO])
		<< `PDC_PRESCALE_SHIFT) |
		pdc_pkg::pdc_mod_t'(cfg[`PDC_FB_A_HI:`PDC_FB_A_LO]);
	wire pdc_pkg::pdc_mod_t mod_a =
		post_mod(cfg[`PDC_POST_A_HI:`PDC_POST_A_LO], 1'b1);
	wire pdc_pkg::pdc_mod_t mod_b =
		post_mod(cfg[`PDC_POST_B_HI:`PDC_POST_B_LO], 1'b0);
	wire pdc_pkg::pdc_mod_t mod_c =
		post_mod(cfg[`PDC_POST_C_HI:`PDC_POST_C_LO], 1'b0);

	// ================================================================
	// divider chain; every divider runs on pclk, the single clock here
	logic tick_a;
	logic tick_b;
	logic ref_q;
	logic fb_q;
	logic post_q;

	pdc_divider u_ref (
		.pclk(pclk), .presetn(presetn), .tick_in(1'b1),
		.modulus(ref_mod), .tick_out(), .clk_out(ref_q));
	pdc_divider u_fb (
		.pclk(pclk), .presetn(presetn), .tick_in(1'b1),
		.modulus(fb_mod), .tick_out(), .clk_out(fb_q));
	// three cascaded post stages; b and c each fed by the previous stage's wrap
	pdc_divider u_post_a (
		.pclk(pclk), .presetn(presetn), .tick_in(1'b1),
		.modulus(mod_a), .tick_out(tick_a), .clk_out());
	pdc_divider u_post_b (
		.pclk(pclk), .presetn(presetn), .tick_in(tick_a),
		.modulus(mod_b), .tick_out(tick_b), .clk_out());
	pdc_divider u_post_c (
		.pclk(pclk), .presetn(presetn), .tick_in(tick_b),
		.modulus(mod_c), .tick_out(), .clk_out(post_q));

	assign ref_div_out = ref_q;
	assign fb_div_out = fb_q;
	assign post_div_out = post_q;
endmodule : pdc_top

// file: src/pdc_xtal_decode.sv
// crystal loop divider table and oscillator power-down decode
`timescale 1ns/1ns
`include "pdc_map.svh"

module pdc_xtal_decode (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// table select code
	input wire logic [2:0] sel,
	// decoded divider and power-down
	output logic [11:0] div_value,
	output logic osc_powerdown
);
	// ================================================================
	// fixed divider table
	function automatic logic [11:0] xtal_div(input logic [2:0] s);
		case (s)
			3'h0: xtal_div = 12'd1;
			3'h1: xtal_div = 12'd3072;
			3'h2: xtal_div = 12'd3156;
			3'h3: xtal_div = 12'd2430;
			3'h4: xtal_div = 12'd2500;
			3'h5: xtal_div = 12'd4000;
			3'h6: xtal_div = 12'd3375;
			default: xtal_div = 12'h000; // all-ones selects no divider
		endcase
	endfunction : xtal_div

	// ================================================================
	// registered so the outputs never glitch while the code changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_value <= 12'h001;
			osc_powerdown <= 1'b0;
		end else begin
			div_value <= xtal_div(sel);
			osc_powerdown <= (sel == `PDC_XTAL_SEL_OFF);
		end
	end
endmodule : pdc_xtal_decode
